// file: cwod_pkg.sv
// Shared constants and types for the configuration word option decoder
package cwod_pkg;
    localparam int unsigned AW = 16;
    localparam int unsigned DW = 16;

    // Register addresses
    localparam logic [AW-1:0] ADDR_EXT_OSC = 16'h8007;
    localparam logic [AW-1:0] ADDR_SYS     = 16'h8008;
    localparam logic [AW-1:0] ADDR_WDT     = 16'h8009;
    localparam logic [AW-1:0] ADDR_PROG    = 16'h800A;
    localparam logic [AW-1:0] ADDR_CTRL    = 16'h8010;
    localparam logic [AW-1:0] ADDR_REMAP   = 16'h8011;
    localparam logic [AW-1:0] ADDR_WDT_RT  = 16'h8012;
    localparam logic [AW-1:0] ADDR_STATUS  = 16'h8013;

    // Erased values, which also serve as implemented-bit masks
    localparam logic [DW-1:0] EXT_ERASED  = 16'h0007;
    localparam logic [DW-1:0] SYS_ERASED  = 16'h3FE7;
    localparam logic [DW-1:0] WDT_ERASED  = 16'h3F7F;
    localparam logic [DW-1:0] PROG_ERASED = 16'h2000;

    // Oscillator, system and programming option word fields
    localparam int unsigned EXT_HI        = 2;
    localparam int unsigned SYS_DEBUG     = 13;
    localparam int unsigned SYS_STACK     = 12;
    localparam int unsigned SYS_ONEWAY    = 11;
    localparam int unsigned SYS_ZC_OFF    = 10;
    localparam int unsigned SYS_BOR_LEVEL = 9;
    localparam int unsigned SYS_DACAUTO   = 8;
    localparam int unsigned SYS_BOR_HI    = 7;
    localparam int unsigned SYS_BOR_LO    = 6;
    localparam int unsigned SYS_LPBOR     = 5;
    localparam int unsigned SYS_PWRT_HI   = 2;
    localparam int unsigned SYS_PWRT_LO   = 1;
    localparam int unsigned SYS_RST_PIN   = 0;
    localparam int unsigned PROG_LV_EN    = 13;

    // Watchdog option word fields
    localparam int unsigned WDT_CCS_HI    = 13;
    localparam int unsigned WDT_CCS_LO    = 11;
    localparam int unsigned WDT_CWS_HI    = 10;
    localparam int unsigned WDT_CWS_LO    = 8;
    localparam int unsigned WDT_MODE_HI   = 6;
    localparam int unsigned WDT_MODE_LO   = 5;
    localparam int unsigned WDT_CPS_HI    = 4;
    localparam int unsigned WDT_CPS_LO    = 0;

    // Runtime control register bits
    localparam int unsigned CTRL_ZC_SW    = 0;
    localparam int unsigned CTRL_ZC_MD    = 1;
    localparam int unsigned CTRL_DAC_RNG  = 2;
    localparam int unsigned CTRL_BOR_SW   = 3;
    localparam int unsigned CTRL_WDT_SW   = 4;
    localparam int unsigned CTRL_RELOAD   = 15;
    localparam int unsigned REMAP_LOCK    = 0;
    localparam int unsigned REMAP_ARMED   = 1;

    // Field encodings
    localparam logic [2:0] EXT_FAST_XTAL  = 3'h2;
    localparam logic [2:0] EXT_MID_XTAL   = 3'h1;
    localparam logic [2:0] EXT_SLOW_XTAL  = 3'h0;
    localparam logic [2:0] CCS_SECONDARY  = 3'h2;
    localparam logic [2:0] CCS_RSV_MAX    = 3'h6;
    localparam logic [2:0] CCS_SW         = 3'h7;
    localparam logic [2:0] CWS_SW_FREE    = 3'h7;
    localparam logic [2:0] CWS_OPEN_MIN   = 3'h6;
    localparam logic [4:0] CPS_SW         = 5'h1F;
    localparam logic [4:0] CPS_SW_DEFAULT = 5'h0B;
    localparam logic [1:0] PWRT_OFF       = 2'h3;
    localparam logic [1:0] PWRT_LONG      = 2'h2;
    localparam logic [1:0] PWRT_MID       = 2'h1;

    typedef enum logic [1:0] {
        CWOD_MODE_OFF    = 2'h0,
        CWOD_MODE_SW     = 2'h1,
        CWOD_MODE_AWAKE  = 2'h2,
        CWOD_MODE_ALWAYS = 2'h3
    } cwod_mode_t;

    // Timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned PWRT_LONG_MS  = 64;
    localparam int unsigned PWRT_MID_MS   = 16;
    localparam int unsigned PWRT_SHORT_MS = 1;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned PWRT_CNT_W    = 20;
endpackage : cwod_pkg

// file: cwod_mode_decode.sv
// Two-bit enable mode decoder shared by brown-out and watchdog
`timescale 1ns/100ps
`default_nettype none
module cwod_mode_decode
    import cwod_pkg::*;
(
    input  wire logic [1:0] mode_in,
    input  wire logic       sw_enable_in,
    input  wire logic       sleep_in,
    output logic            enable_out
);
    always_comb begin
        case (cwod_mode_t'(mode_in))
            CWOD_MODE_ALWAYS: enable_out = 1'b1;
            CWOD_MODE_AWAKE:  enable_out = !sleep_in;
            CWOD_MODE_SW:     enable_out = sw_enable_in;
            default:          enable_out = 1'b0;
        endcase
    end
endmodule : cwod_mode_decode
`default_nettype wire

// file: cwod_delay_timer.sv
// Power-up delay counter started by a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module cwod_delay_timer
    import cwod_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  start_in,
    input  wire logic                  bypass_in,
    input  wire logic [PWRT_CNT_W-1:0] length_in,
    output logic                       done_out
);
    typedef struct packed {
        logic [PWRT_CNT_W-1:0] cnt;
        logic                  running;
        logic                  done;
    } cwod_tmr_t;

    cwod_tmr_t s_reg;
    cwod_tmr_t s_next;

    always_comb begin
        s_next = s_reg;
        if (start_in) begin
            s_next.cnt     = '0;
            s_next.running = !bypass_in;
            s_next.done    = bypass_in;
        end else if (s_reg.running) begin
            if (s_reg.cnt >= length_in - 1'b1) begin
                s_next.running = 1'b0;
                s_next.done    = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done_out = s_reg.done;

    AST_PWRT_NOT_EARLY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (s_reg.running && !start_in && s_reg.cnt < length_in - 1'b1) |=> !done_out)
        else $error("power-up delay ended early");
endmodule : cwod_delay_timer
`default_nettype wire

// file: cwod_config_word_option_decode.sv
// Configuration word storage, sampling and option decode
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module cwod_config_word_option_decode
    import cwod_pkg::*;
#(
    parameter logic [PWRT_CNT_W-1:0] PWRT_LONG_CYC  =
        PWRT_CNT_W'(PWRT_LONG_MS * (CLK_HZ / MS_PER_S)),
    parameter logic [PWRT_CNT_W-1:0] PWRT_MID_CYC   =
        PWRT_CNT_W'(PWRT_MID_MS * (CLK_HZ / MS_PER_S)),
    parameter logic [PWRT_CNT_W-1:0] PWRT_SHORT_CYC =
        PWRT_CNT_W'(PWRT_SHORT_MS * (CLK_HZ / MS_PER_S))
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic          wr_in,
    input  wire logic          rd_in,
    output logic      [DW-1:0] rdata_out,
    input  wire logic          sleep_in,
    input  wire logic          stack_overflow_in,
    input  wire logic          stack_underflow_in,
    input  wire logic          remap_unlock_in,
    output logic               high_speed_crystal_out,
    output logic               medium_crystal_out,
    output logic               low_power_crystal_out,
    output logic               debugger_en_out,
    output logic               stack_reset_out,
    output logic               remap_lock_flag_out,
    output logic               zero_cross_en_out,
    output logic               dac_range_auto_out,
    output logic               dac_range_sel_out,
    output logic               brownout_en_out,
    output logic               brownout_level_sel_out,
    output logic               low_power_brownout_en_out,
    output logic               powerup_done_out,
    output logic               master_clear_reset_fn_out,
    output logic               watchdog_en_out,
    output logic      [2:0]    watchdog_clock_sel_out,
    output logic               watchdog_clock_sw_out,
    output logic               watchdog_clock_reserved_out,
    output logic      [2:0]    watchdog_window_out,
    output logic               watchdog_window_open_out,
    output logic      [4:0]    watchdog_period_runtime_out,
    output logic               config_loaded_out
);
    typedef struct packed {
        logic [2:0]    ext_w;
        logic [DW-1:0] sys_w;
        logic [DW-1:0] wdt_w;
        logic          prog_lv;
        logic          zc_sw;
        logic          zc_md;
        logic          dac_rng;
        logic          bor_sw;
        logic          wdt_sw;
        logic [2:0]    cfg_ext;
        logic [DW-1:0] cfg_sys;
        logic [DW-1:0] cfg_wdt;
        logic          cfg_lv;
        logic          loaded;
        logic          start;
        logic          unlock_armed;
        logic          lock_flag;
        logic          lock_used;
        logic [4:0]    rt_period;
        logic [2:0]    rt_window;
        logic [DW-1:0] rdata;
        logic          stack_rst;
        logic          zc_en;
        logic          dac_sel;
        logic          bor_en;
        logic          wdt_en;
    } cwod_state_t;

    localparam cwod_state_t ST_RESET = '{
        ext_w:    EXT_ERASED[EXT_HI:0],
        sys_w:    SYS_ERASED,
        wdt_w:    WDT_ERASED,
        prog_lv:  PROG_ERASED[PROG_LV_EN],
        default:  '0
    };

    cwod_state_t s_reg;
    cwod_state_t s_next;

    logic                  bor_mode_en;
    logic                  wdt_mode_en;
    logic [1:0]            wdt_mode;
    logic [PWRT_CNT_W-1:0] pwrt_len;
    logic                  pwrt_bypass;
    logic [DW-1:0]         status_word;
    logic                  reload_req;

    assign wdt_mode = s_reg.cfg_wdt[WDT_MODE_HI:WDT_MODE_LO];
    assign reload_req = wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_RELOAD];

    cwod_mode_decode u_bor_mode (
        .mode_in      (s_reg.cfg_sys[SYS_BOR_HI:SYS_BOR_LO]),
        .sw_enable_in (s_reg.bor_sw),
        .sleep_in     (sleep_in),
        .enable_out   (bor_mode_en)
    );

    cwod_mode_decode u_wdt_mode (
        .mode_in      (wdt_mode),
        .sw_enable_in (s_reg.wdt_sw),
        .sleep_in     (sleep_in),
        .enable_out   (wdt_mode_en)
    );

    always_comb begin
        pwrt_bypass = 1'b0;
        case (s_reg.cfg_sys[SYS_PWRT_HI:SYS_PWRT_LO])
            PWRT_OFF: begin
                pwrt_len    = PWRT_SHORT_CYC;
                pwrt_bypass = 1'b1;
            end
            PWRT_LONG: pwrt_len = PWRT_LONG_CYC;
            PWRT_MID:  pwrt_len = PWRT_MID_CYC;
            default:   pwrt_len = PWRT_SHORT_CYC;
        endcase
    end

    cwod_delay_timer u_pwrt (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (s_reg.start),
        .bypass_in  (pwrt_bypass),
        .length_in  (pwrt_len),
        .done_out   (powerup_done_out)
    );

    assign status_word = {8'h00, debugger_en_out, master_clear_reset_fn_out,
                          s_reg.zc_en, s_reg.wdt_en, s_reg.bor_en, s_reg.lock_flag,
                          powerup_done_out, s_reg.loaded};

    always_comb begin
        s_next       = s_reg;
        s_next.rdata = '0;
        s_next.start = 1'b0;

        // Capture the words once on reset exit or reload
        if (!s_reg.loaded) begin
            s_next.cfg_ext   = s_reg.ext_w;
            s_next.cfg_sys   = s_reg.sys_w;
            s_next.cfg_wdt   = s_reg.wdt_w;
            s_next.cfg_lv    = s_reg.prog_lv;
            s_next.loaded    = 1'b1;
            s_next.start     = 1'b1;
            s_next.lock_flag = 1'b0;
            s_next.lock_used = 1'b0;
            s_next.rt_window = s_reg.wdt_w[WDT_CWS_HI:WDT_CWS_LO];
            if (s_reg.wdt_w[WDT_CPS_HI:WDT_CPS_LO] == CPS_SW) begin
                s_next.rt_period = CPS_SW_DEFAULT;
            end else begin
                s_next.rt_period = s_reg.wdt_w[WDT_CPS_HI:WDT_CPS_LO];
            end
        end

        if (wr_in) begin
            case (addr_in)
                ADDR_EXT_OSC: s_next.ext_w = wdata_in[EXT_HI:0];
                ADDR_SYS:     s_next.sys_w = wdata_in & SYS_ERASED;
                ADDR_WDT:     s_next.wdt_w = wdata_in & WDT_ERASED;
                ADDR_PROG:    s_next.prog_lv = wdata_in[PROG_LV_EN];
                ADDR_CTRL: begin
                    s_next.zc_sw   = wdata_in[CTRL_ZC_SW];
                    s_next.zc_md   = wdata_in[CTRL_ZC_MD];
                    s_next.dac_rng = wdata_in[CTRL_DAC_RNG];
                    s_next.bor_sw  = wdata_in[CTRL_BOR_SW];
                    s_next.wdt_sw  = wdata_in[CTRL_WDT_SW];
                    if (wdata_in[CTRL_RELOAD]) begin
                        s_next.loaded = 1'b0;
                    end
                end
                ADDR_REMAP: begin
                    s_next.unlock_armed = 1'b0;
                    if (s_reg.unlock_armed) begin
                        if (s_reg.cfg_sys[SYS_ONEWAY]) begin
                            // One-way: a single set, cleared only by reset or reload
                            if (!s_reg.lock_used && wdata_in[REMAP_LOCK]) begin
                                s_next.lock_flag = 1'b1;
                                s_next.lock_used = 1'b1;
                            end
                        end else begin
                            s_next.lock_flag = wdata_in[REMAP_LOCK];
                        end
                    end
                end
                ADDR_WDT_RT: begin
                    if (s_reg.cfg_wdt[WDT_CPS_HI:WDT_CPS_LO] == CPS_SW) begin
                        s_next.rt_period = wdata_in[WDT_CPS_HI:WDT_CPS_LO];
                    end
                    if (s_reg.cfg_wdt[WDT_CWS_HI:WDT_CWS_LO] == CWS_SW_FREE) begin
                        s_next.rt_window = wdata_in[WDT_CWS_HI:WDT_CWS_LO];
                    end
                end
                default: ;
            endcase
        end

        // Arming wins over the disarm of a same-cycle write
        if (remap_unlock_in) begin
            s_next.unlock_armed = 1'b1;
        end

        if (rd_in) begin
            case (addr_in)
                ADDR_EXT_OSC: s_next.rdata = {13'h0000, s_reg.ext_w};
                ADDR_SYS:     s_next.rdata = s_reg.sys_w;
                ADDR_WDT:     s_next.rdata = s_reg.wdt_w;
                ADDR_PROG:    s_next.rdata = {2'h0, s_reg.prog_lv, 13'h0000};
                ADDR_CTRL:    s_next.rdata = {11'h000, s_reg.wdt_sw, s_reg.bor_sw,
                                              s_reg.dac_rng, s_reg.zc_md, s_reg.zc_sw};
                ADDR_REMAP:   s_next.rdata = {14'h0000, s_reg.unlock_armed,
                                              s_reg.lock_flag};
                ADDR_WDT_RT:  s_next.rdata = {5'h00, s_reg.rt_window, 3'h0,
                                              s_reg.rt_period};
                ADDR_STATUS:  s_next.rdata = status_word;
                default:      s_next.rdata = '0;
            endcase
        end

        // Live settings, all but dac_sel forced inactive until the words are sampled
        s_next.stack_rst = s_reg.loaded && s_reg.cfg_sys[SYS_STACK] &&
                           (stack_overflow_in || stack_underflow_in);
        if (!s_reg.cfg_sys[SYS_ZC_OFF]) begin
            s_next.zc_en = s_reg.loaded;
        end else begin
            s_next.zc_en = s_reg.loaded && s_reg.zc_sw && !s_reg.zc_md;
        end
        s_next.dac_sel = s_reg.cfg_sys[SYS_DACAUTO] && s_reg.dac_rng;
        s_next.bor_en  = s_reg.loaded && bor_mode_en;
        s_next.wdt_en  = s_reg.loaded && wdt_mode_en;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_reg <= ST_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_out                 = s_reg.rdata;
    assign config_loaded_out         = s_reg.loaded;
    assign high_speed_crystal_out    = s_reg.cfg_ext == EXT_FAST_XTAL;
    assign medium_crystal_out        = s_reg.cfg_ext == EXT_MID_XTAL;
    assign low_power_crystal_out     = s_reg.cfg_ext == EXT_SLOW_XTAL;
    assign debugger_en_out           = !s_reg.cfg_sys[SYS_DEBUG];
    assign stack_reset_out           = s_reg.stack_rst;
    assign remap_lock_flag_out       = s_reg.lock_flag;
    assign zero_cross_en_out         = s_reg.zc_en;
    assign dac_range_auto_out        = !s_reg.cfg_sys[SYS_DACAUTO];
    assign dac_range_sel_out         = s_reg.dac_sel;
    assign brownout_en_out           = s_reg.bor_en;
    assign brownout_level_sel_out    = s_reg.cfg_sys[SYS_BOR_LEVEL];
    assign low_power_brownout_en_out = !s_reg.cfg_sys[SYS_LPBOR];
    assign master_clear_reset_fn_out = s_reg.cfg_lv || s_reg.cfg_sys[SYS_RST_PIN];
    assign watchdog_en_out           = s_reg.wdt_en;
    assign watchdog_clock_sel_out    = (wdt_mode == CWOD_MODE_OFF) ? 3'h0 :
                                       s_reg.cfg_wdt[WDT_CCS_HI:WDT_CCS_LO];
    assign watchdog_clock_sw_out     = (wdt_mode != CWOD_MODE_OFF) &&
                                       (s_reg.cfg_wdt[WDT_CCS_HI:WDT_CCS_LO] == CCS_SW);
    assign watchdog_clock_reserved_out = (wdt_mode != CWOD_MODE_OFF) &&
                                       (s_reg.cfg_wdt[WDT_CCS_HI:WDT_CCS_LO] > CCS_SECONDARY) &&
                                       (s_reg.cfg_wdt[WDT_CCS_HI:WDT_CCS_LO] <= CCS_RSV_MAX);
    assign watchdog_window_out       = s_reg.rt_window;
    assign watchdog_window_open_out  = s_reg.rt_window >= CWS_OPEN_MIN;
    assign watchdog_period_runtime_out = s_reg.rt_period;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_reload;
        reload_req;
    endsequence

    sequence seq_resample;
        !s_reg.loaded ##1 (s_reg.loaded && s_reg.cfg_sys == $past(s_reg.sys_w));
    endsequence

    AST_RELOAD_SAMPLES: assert property (seq_reload |=> seq_resample)
        else $error("reload did not resample words");
    AST_CFG_HOLD: assert property ((s_reg.loaded && $past(s_reg.loaded)) |->
        $stable(s_reg.cfg_sys) && $stable(s_reg.cfg_wdt))
        else $error("sampled configuration changed");
    AST_DEBUG_POLARITY: assert property ((s_reg.loaded && !$past(s_reg.loaded)) |->
        debugger_en_out == !$past(s_reg.sys_w[SYS_DEBUG]))
        else $error("debugger enable polarity wrong");
    AST_STACK_RESET: assert property ((s_reg.loaded &&
        (stack_overflow_in || stack_underflow_in)) |=>
        stack_reset_out == $past(s_reg.cfg_sys[SYS_STACK]))
        else $error("stack fault reset mismatch");
    AST_LOCK_ONE_WAY: assert property ((s_reg.lock_flag &&
        s_reg.cfg_sys[SYS_ONEWAY] && s_reg.loaded && !reload_req) |=> s_reg.lock_flag)
        else $error("one-way remap lock was cleared");
    AST_ZC_FORCED: assert property ((s_reg.loaded && !s_reg.cfg_sys[SYS_ZC_OFF] &&
        !reload_req) |=> zero_cross_en_out)
        else $error("zero-cross not forced on");
    AST_BOR_ALWAYS: assert property ((s_reg.loaded && !reload_req &&
        s_reg.cfg_sys[SYS_BOR_HI:SYS_BOR_LO] == CWOD_MODE_ALWAYS) |=> brownout_en_out)
        else $error("brown-out not always enabled");
    AST_RSTPIN_LOWVOLT: assert property ((s_reg.loaded && !$past(s_reg.loaded) &&
        $past(s_reg.prog_lv)) |-> master_clear_reset_fn_out)
        else $error("master-clear not reset under low-voltage programming");
    AST_WDT_OFF: assert property ((s_reg.loaded && wdt_mode == CWOD_MODE_OFF) |=>
        !watchdog_en_out[*2])
        else $error("watchdog enabled in off mode");
    AST_PERIOD_FIXED: assert property ((s_reg.loaded && $past(s_reg.loaded) &&
        s_reg.cfg_wdt[WDT_CPS_HI:WDT_CPS_LO] != CPS_SW) |-> $stable(s_reg.rt_period))
        else $error("fixed watchdog period changed");
    AST_WINDOW_FIXED: assert property ((s_reg.loaded && $past(s_reg.loaded) &&
        s_reg.cfg_wdt[WDT_CWS_HI:WDT_CWS_LO] != CWS_SW_FREE) |-> $stable(s_reg.rt_window))
        else $error("locked watchdog window changed");
    // Period default lands the cycle after capture unless software wrote alongside
    AST_PERIOD_DEFAULT: assert property ((s_reg.loaded && !$past(s_reg.loaded) &&
        !$past(wr_in) && $past(s_reg.wdt_w[WDT_CPS_HI:WDT_CPS_LO]) == CPS_SW) |->
        watchdog_period_runtime_out == CPS_SW_DEFAULT)
        else $error("watchdog period default not loaded");
endmodule : cwod_config_word_option_decode
`default_nettype wire

// file: tb.sv
// Self-checking bench for the configuration word option decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cwod_pkg::*;
    localparam int PL = 40, PM = 20, PS = 5;
    logic        clk, rst_n, wr, rd, slp, so, su, unl, m, ld;
    logic [15:0] ad, wd, q, rq, s, w, e, x;
    logic [4:0]  c;
    logic [2:0]  k, wcs, win;
    logic [4:0]  per;
    logic        fx, mx, sx, dbg, stk, lk, zc, da, ds, bor, bv, lpb, pud, mc, wen, wsw, wrs, wop;
    logic [31:0] st = 32'h4D98;
    int          mismatches = 0, num_checks = 0, cyc = 0, n;
    cwod_config_word_option_decode #(.PWRT_LONG_CYC(20'(PL)), .PWRT_MID_CYC(20'(PM)),
        .PWRT_SHORT_CYC(20'(PS))) i_cwod_config_word_option_decode (
        .sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(ad), .wdata_in(wd), .wr_in(wr),
        .rd_in(rd), .rdata_out(q), .sleep_in(slp), .stack_overflow_in(so),
        .stack_underflow_in(su), .remap_unlock_in(unl), .high_speed_crystal_out(fx),
        .medium_crystal_out(mx), .low_power_crystal_out(sx), .debugger_en_out(dbg),
        .stack_reset_out(stk), .remap_lock_flag_out(lk), .zero_cross_en_out(zc),
        .dac_range_auto_out(da), .dac_range_sel_out(ds), .brownout_en_out(bor),
        .brownout_level_sel_out(bv), .low_power_brownout_en_out(lpb), .powerup_done_out(pud),
        .master_clear_reset_fn_out(mc), .watchdog_en_out(wen), .watchdog_clock_sel_out(wcs),
        .watchdog_clock_sw_out(wsw), .watchdog_clock_reserved_out(wrs),
        .watchdog_window_out(win), .watchdog_window_open_out(wop),
        .watchdog_period_runtime_out(per), .config_loaded_out(ld));
    function automatic logic [15:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st[15:0];
    endfunction : rnd
    function automatic int plen(input logic [1:0] p);
        return (p == 2'h3) ? 1 : (p == 2'h2) ? PL : (p == 2'h1) ? PM : PS;
    endfunction : plen
    task automatic chk(input logic [15:0] seen, exp, input string nm);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrt(input logic [15:0] a, d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask : wrt
    task automatic rdd(input logic [15:0] a);
        @(posedge clk);
        ad <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 rq = q;
    endtask : rdd
    task automatic unlock();
        @(posedge clk);
        unl <= 1'h1;
        @(posedge clk);
        unl <= 1'h0;
    endtask : unlock
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        {rst_n, wr, rd, slp, so, su, unl} = 7'h0;
        ad = 16'h0;
        wd = 16'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        rdd(ADDR_SYS); chk(rq, SYS_ERASED, "sys word");
        rdd(ADDR_WDT); chk(rq, WDT_ERASED, "wdt word");
        wrt(16'h8020, 16'hFFFF); rdd(16'h8020); chk(rq, 16'h0, "unmapped");
        for (int i = 0; i < 40; i++) begin
            s = (i == 0) ? SYS_ERASED : rnd() & SYS_ERASED;
            w = (i == 0) ? WDT_ERASED : (i == 1) ? 16'h0 : rnd() & WDT_ERASED;
            e = rnd() & EXT_ERASED;
            x = rnd();
            c = x[4:0];
            slp <= x[5];
            wrt(ADDR_SYS, s); wrt(ADDR_WDT, w); wrt(ADDR_EXT_OSC, e);
            wrt(ADDR_PROG, {2'h0, x[6], 13'h0}); wrt(ADDR_CTRL, {11'h0, c});
            wrt(ADDR_CTRL, {1'h1, 10'h0, c});
            n = 0;
            // Done flag from the previous run stands until the timer restarts
            do begin @(posedge clk); #1 n++; end while ((n < 2 || pud !== 1'h1) && n < 100);
            chk(16'(n >= plen(s[2:1]) && n <= plen(s[2:1]) + 6), 16'h1, "pwrt");
            chk(ld, 1'h1, "loaded");
            m = (w[6:5] != 2'h0);
            k = w[13:11];
            chk({fx, mx, sx}, {e[2:0] == 3'h2, e[2:0] == 3'h1, e[2:0] == 3'h0}, "osc");
            chk(dbg, !s[13], "dbg");
            chk(zc, !s[10] | (c[0] & !c[1]), "zc");
            chk({da, ds}, {!s[8], s[8] & c[2]}, "dac");
            chk(bor, s[7] ? (s[6] | !x[5]) : (s[6] & c[3]), "bor");
            chk({bv, lpb}, {s[9], !s[5]}, "bor level");
            chk(mc, x[6] | s[0], "mc pin");
            chk({wcs, wsw, wrs}, {m ? k : 3'h0, m && k == 3'h7, m && k >= 3'h3 && k <= 3'h6}, "wclk");
            chk(wen, w[6] ? (w[5] | !x[5]) : (w[5] & c[4]), "wen");
            chk({win, wop, per}, {w[10:8], w[10:9] == 2'h3, w[4:0] == 5'h1F ? 5'hB : w[4:0]}, "wdog");
            @(posedge clk);
            {so, su} <= i[0] ? 2'h1 : 2'h2;
            @(posedge clk);
            {so, su} <= 2'h0;
            #1 chk(stk, s[12], "stack");
            x = rnd();
            wrt(ADDR_WDT_RT, {5'h0, x[10:8], 3'h0, x[4:0]});
            chk(win, w[10:8] == 3'h7 ? x[10:8] : w[10:8], "win sw");
            chk(per, w[4:0] == 5'h1F ? x[4:0] : w[4:0], "per sw");
            unlock(); wrt(ADDR_REMAP, 16'h1); chk(lk, 1'h1, "lock set");
            unlock(); wrt(ADDR_REMAP, 16'h0); chk(lk, s[11], "lock clr");
            wrt(ADDR_REMAP, 16'h1); chk(lk, s[11], "lock unarmed");
            rdd(ADDR_REMAP); chk(rq, {15'h0, s[11]}, "remap rd");
            wrt(ADDR_SYS, s ^ 16'h2000); chk(dbg, !s[13], "dbg hold");
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule : tb
`default_nettype wire
